/* rtl/adc_ctl_map.vh */
// register offsets, field positions and reset values of the converter control block
`ifndef ADC_CTL_MAP_VH
`define ADC_CTL_MAP_VH

// ======================================================================
// byte offsets
`define OFS_RESULT_HIGH 12'h000
`define OFS_RESULT_LOW 12'h004
`define OFS_MAIN_CONTROL 12'h008
`define OFS_INPUT_CLOCK_CFG 12'h00c
`define OFS_MODE_TEMPSENSE 12'h010
`define OFS_REF_OUTPUT 12'h014
`define OFS_IRQ_STATUS 12'h018
`define OFS_IRQ_MASK 12'h01c

// ======================================================================
// main control fields
`define MC_START 7
`define MC_BUSY 6
`define MC_ENABLE 5
`define MC_FORMAT 4
`define MC_CHAN_HI 3
`define MC_CHAN_LO 0

// ======================================================================
// input and clock config fields
`define IC_INS_HI 7
`define IC_INS_LO 5
`define IC_REF_HI 4
`define IC_REF_LO 3
`define IC_CLK_HI 2
`define IC_CLK_LO 0

// ======================================================================
// mode and temp sensor fields
`define MT_MODE 7
`define MT_AUX 1
`define MT_TEMP_SENSOR_ENABLE 0
`define MT_RESET 8'h02
`define MT_MASK 8'h83

// reference output enable
`define RO_EN 0

// ======================================================================
// interrupt bits
`define IRQ_DONE 0
`define IRQ_START 1
`define IRQ_WIDTH 2

// ======================================================================
// misc
`define REG_RESET 8'h00
`define RESULT_W 12
`define DATA_W 8
`define CONV_CYCLES 5'd16

`endif

/* rtl/conv_clock_div.v */
// conversion clock divider producing one-cycle enable pulses
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_map.vh"

module conv_clock_div (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire [2:0] clk_sel,
    output wire tick
);
    reg [6:0] cnt_ff;
    wire [6:0] limit;

    // divide by 2^clk_sel
    assign limit = (7'h01 << clk_sel) - 7'h01;
    assign tick = run && (cnt_ff >= limit);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 7'h00;
        end else if (!run || tick) begin
            cnt_ff <= 7'h00;
        end else begin
            cnt_ff <= cnt_ff + 7'h01;
        end
    end
endmodule
`default_nettype wire

/* rtl/result_format.v */
// presents the stored 12-bit result in the selected justification
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_map.vh"

module result_format (
    input wire [11:0] result,
    input wire fmt,
    output wire [7:0] high_byte,
    output wire [7:0] low_byte
);
    // unused positions zero
    assign high_byte = fmt ? {4'h0, result[11:8]} : result[11:4];
    assign low_byte = fmt ? result[7:0] : {result[3:0], 4'h0};
endmodule
`default_nettype wire

/* rtl/adc_result_and_control_regs.v */
// converter control registers, conversion sequencer and result registers
// ======================================================================
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_map.vh"

module adc_result_and_control_regs #(
    parameter CONV_TICKS = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [11:0] sample_data,
    output reg [2:0] input_signal_select,
    output reg [3:0] external_channel_select,
    output reg [1:0] reference_select,
    output reg converter_enable,
    output reg conversion_mode_select,
    output reg temp_sensor_enable,
    output reg reference_output_enable,
    output reg sample_strobe,
    output wire irq
);
    // ==================================================================
    // register state
    reg start_ff;
    reg busy_ff;
    reg fmt_ff;
    reg [3:0] chan_ff;
    reg [7:0] incfg_ff;
    reg mode_ff;
    reg aux_ff;
    reg temp_sensor_enable_ff;
    reg refen_ff;
    reg [11:0] result_ff;
    reg [`IRQ_WIDTH-1:0] irq_stat_ff;
    reg [`IRQ_WIDTH-1:0] irq_mask_ff;
    reg [4:0] step_ff;
    reg [11:0] sample_ff;
    reg [11:0] sample_sync_ff;
    reg nxt_busy;
    reg [4:0] nxt_step;
    reg [11:0] nxt_result;

    // sequencer states, held in busy_ff
    localparam ST_IDLE = 1'b0;
    localparam ST_CONVERT = 1'b1;

    wire wr_en;
    wire rd_en;
    wire [7:0] res_high;
    wire [7:0] res_low;
    wire conv_tick;
    wire start_fall;
    wire conv_done;
    wire [`IRQ_WIDTH-1:0] irq_set;
    wire [`IRQ_WIDTH-1:0] irq_clr;
    wire [`IRQ_WIDTH-1:0] nxt_irq_stat;
    reg [7:0] nxt_main;
    reg mapped;
    genvar gi;

    function addr_hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            addr_hit = (a == ofs);
        end
    endfunction

    // ==================================================================
    // apb slave, zero wait states
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !pwrite;
    assign pslverr = psel && penable && !mapped;

    always @* begin
        mapped = addr_hit(paddr, `OFS_RESULT_HIGH) || addr_hit(paddr, `OFS_RESULT_LOW)
            || addr_hit(paddr, `OFS_MAIN_CONTROL) || addr_hit(paddr, `OFS_INPUT_CLOCK_CFG)
            || addr_hit(paddr, `OFS_MODE_TEMPSENSE) || addr_hit(paddr, `OFS_REF_OUTPUT)
            || addr_hit(paddr, `OFS_IRQ_STATUS) || addr_hit(paddr, `OFS_IRQ_MASK);
    end

    always @* begin
        nxt_main = 8'h00;
        nxt_main[`MC_START] = start_ff;
        nxt_main[`MC_BUSY] = busy_ff;
        nxt_main[`MC_ENABLE] = converter_enable;
        nxt_main[`MC_FORMAT] = fmt_ff;
        nxt_main[`MC_CHAN_HI:`MC_CHAN_LO] = chan_ff;
    end

    // read data registered in setup phase, valid in access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            prdata <= 32'h0000_0000;
            if (addr_hit(paddr, `OFS_RESULT_HIGH)) begin
                prdata[7:0] <= res_high;
            end
            if (addr_hit(paddr, `OFS_RESULT_LOW)) begin
                prdata[7:0] <= res_low;
            end
            if (addr_hit(paddr, `OFS_MAIN_CONTROL)) begin
                prdata[7:0] <= nxt_main;
            end
            if (addr_hit(paddr, `OFS_INPUT_CLOCK_CFG)) begin
                prdata[7:0] <= incfg_ff;
            end
            if (addr_hit(paddr, `OFS_MODE_TEMPSENSE)) begin
                prdata[7:0] <= {mode_ff, 5'h00, aux_ff, temp_sensor_enable_ff};
            end
            if (addr_hit(paddr, `OFS_REF_OUTPUT)) begin
                prdata[7:0] <= {7'h00, refen_ff};
            end
            if (addr_hit(paddr, `OFS_IRQ_STATUS)) begin
                prdata[`IRQ_WIDTH-1:0] <= irq_stat_ff;
            end
            if (addr_hit(paddr, `OFS_IRQ_MASK)) begin
                prdata[`IRQ_WIDTH-1:0] <= irq_mask_ff;
            end
        end
    end

    // ==================================================================
    // writable control registers; result registers have no write path
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_ff <= 1'b0;
            converter_enable <= 1'b0;
            fmt_ff <= 1'b0;
            chan_ff <= 4'h0;
            incfg_ff <= `REG_RESET;
            mode_ff <= 1'b0;
            aux_ff <= 1'b1;
            temp_sensor_enable_ff <= 1'b0;
            refen_ff <= 1'b0;
            irq_mask_ff <= {`IRQ_WIDTH{1'b0}};
        end else if (wr_en) begin
            if (addr_hit(paddr, `OFS_MAIN_CONTROL)) begin
                start_ff <= pwdata[`MC_START];
                converter_enable <= pwdata[`MC_ENABLE];
                fmt_ff <= pwdata[`MC_FORMAT];
                chan_ff <= pwdata[`MC_CHAN_HI:`MC_CHAN_LO];
            end
            if (addr_hit(paddr, `OFS_INPUT_CLOCK_CFG)) begin
                incfg_ff <= pwdata[7:0];
            end
            if (addr_hit(paddr, `OFS_MODE_TEMPSENSE)) begin
                mode_ff <= pwdata[`MT_MODE];
                aux_ff <= pwdata[`MT_AUX];
                temp_sensor_enable_ff <= pwdata[`MT_TEMP_SENSOR_ENABLE];
            end
            if (addr_hit(paddr, `OFS_REF_OUTPUT)) begin
                refen_ff <= pwdata[`RO_EN];
            end
            if (addr_hit(paddr, `OFS_IRQ_MASK)) begin
                irq_mask_ff <= pwdata[`IRQ_WIDTH-1:0];
            end
        end
    end

    // source selection to the analog front end
    always @* begin
        input_signal_select = incfg_ff[`IC_INS_HI:`IC_INS_LO];
        external_channel_select = chan_ff;
        reference_select = incfg_ff[`IC_REF_HI:`IC_REF_LO];
        conversion_mode_select = mode_ff;
        temp_sensor_enable = temp_sensor_enable_ff;
        reference_output_enable = refen_ff;
    end

    // ==================================================================
    // conversion sequencer
    // start taken on high-to-low of the start bit, not its level
    assign start_fall = wr_en && addr_hit(paddr, `OFS_MAIN_CONTROL)
        && start_ff && !pwdata[`MC_START] && converter_enable;

    conv_clock_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(busy_ff),
        .clk_sel(incfg_ff[`IC_CLK_HI:`IC_CLK_LO]),
        .tick(conv_tick)
    );

    assign conv_done = busy_ff && conv_tick && (step_ff == CONV_TICKS[4:0] - 5'd1);

    // analog sample from outside the clock domain
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_sync_ff <= 12'h000;
            sample_ff <= 12'h000;
        end else begin
            sample_sync_ff <= sample_data;
            sample_ff <= sample_sync_ff;
        end
    end

    // next state; a start while busy restarts the step count
    always @* begin
        nxt_busy = busy_ff;
        nxt_step = step_ff;
        nxt_result = result_ff;
        case (busy_ff)
            ST_IDLE: begin
                nxt_step = 5'h00;
                if (start_fall) begin
                    nxt_busy = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (start_fall) begin
                    nxt_step = 5'h00;
                end else if (conv_done) begin
                    nxt_busy = ST_IDLE;
                    nxt_result = sample_ff;
                end else if (conv_tick) begin
                    nxt_step = step_ff + 5'h01;
                end
            end
            default: begin
                nxt_busy = ST_IDLE;
            end
        endcase
        // disabling aborts the conversion, result kept
        if (!converter_enable) begin
            nxt_busy = ST_IDLE;
            nxt_step = 5'h00;
            nxt_result = result_ff;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff <= ST_IDLE;
            step_ff <= 5'h00;
            result_ff <= 12'h000;
            sample_strobe <= 1'b0;
        end else begin
            busy_ff <= nxt_busy;
            step_ff <= nxt_step;
            result_ff <= nxt_result;
            sample_strobe <= start_fall;
        end
    end

    result_format u_fmt (
        .result(result_ff),
        .fmt(fmt_ff),
        .high_byte(res_high),
        .low_byte(res_low)
    );

    // ==================================================================
    // interrupts: set wins over write-one-to-clear
    assign irq_set[`IRQ_DONE] = conv_done;
    assign irq_set[`IRQ_START] = start_fall;
    assign irq_clr = (wr_en && addr_hit(paddr, `OFS_IRQ_STATUS))
        ? pwdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

    generate
        for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1) begin : g_irq
            assign nxt_irq_stat[gi] = irq_set[gi] | (irq_stat_ff[gi] & ~irq_clr[gi]);
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= {`IRQ_WIDTH{1'b0}};
        end else begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);
endmodule
`default_nettype wire

/* tb/adc_ctl_checker_props.sv */
// checker of bus answers and register-driven outputs
`timescale 1ns/1ps
`default_nettype none
module adc_ctl_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] input_signal_select,
    input wire logic [3:0] external_channel_select,
    input wire logic [1:0] reference_select,
    input wire logic converter_enable,
    input wire logic conversion_mode_select,
    input wire logic temp_sensor_enable,
    input wire logic reference_output_enable,
    input wire logic sample_strobe,
    input wire logic irq
);
    logic wr;
    logic start_ff;
    assign wr = psel && penable && pwrite && pready;
    // last start value written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            start_ff <= 1'b0;
        else if (wr && paddr == 12'h008)
            start_ff <= pwdata[7];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ======================================================================
    // assertions
    chk_start_fall: assert property (
        wr && paddr == 12'h008 && start_ff && !pwdata[7] && pwdata[5] && converter_enable
        |=> sample_strobe) else $error("start sequence gave no strobe");
    chk_level_nostart: assert property (
        wr && paddr == 12'h008 && pwdata[7] |=> !sample_strobe) else $error("strobe on level");
    chk_strobe_once: assert property (sample_strobe |=> !sample_strobe)
        else $error("strobe longer than one cycle");
    chk_main_fields: assert property (
        wr && paddr == 12'h008 |=> converter_enable == $past(pwdata[5])
        && external_channel_select == $past(pwdata[3:0])) else $error("main fields wrong");
    chk_clock_cfg: assert property (
        wr && paddr == 12'h00c |=> input_signal_select == $past(pwdata[7:5])
        && reference_select == $past(pwdata[4:3])) else $error("input config wrong");
    chk_mode_fields: assert property (
        wr && paddr == 12'h010 |=> conversion_mode_select == $past(pwdata[7])
        && temp_sensor_enable == $past(pwdata[0])) else $error("mode fields wrong");
    chk_ref_enable: assert property (
        wr && paddr == 12'h014 |=> reference_output_enable == $past(pwdata[0]))
        else $error("reference enable wrong");
    chk_unmapped_err: assert property (psel && penable && paddr > 12'h01c |-> pslverr)
        else $error("no error on unmapped address");
    chk_mapped_ok: assert property (
        psel && penable && paddr <= 12'h01c && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped address");
    cover property (sample_strobe);
    cover property (irq);
    cover property (pslverr);
endmodule
bind adc_result_and_control_regs adc_ctl_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .input_signal_select(input_signal_select),
    .external_channel_select(external_channel_select), .reference_select(reference_select),
    .converter_enable(converter_enable), .conversion_mode_select(conversion_mode_select),
    .temp_sensor_enable(temp_sensor_enable), .reference_output_enable(reference_output_enable),
    .sample_strobe(sample_strobe), .irq(irq));
`default_nettype wire

/* tb/adc_result_and_control_regs_bench.sv */
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_result_and_control_regs_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [11:0] sample_data = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire irq;
    int n_fail = 0;
    int samples_checked = 0;
    int cnt;
    logic [63:0] q[$];
    logic [63:0] e;
    logic [11:0] res;
    always #20 pclk = ~pclk;
    adc_result_and_control_regs #(.CONV_TICKS(16)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_data(sample_data),
        .input_signal_select(), .external_channel_select(), .reference_select(),
        .converter_enable(), .conversion_mode_select(), .temp_sensor_enable(),
        .reference_output_enable(), .sample_strobe(), .irq(irq));
    // ======================================================================
    // tasks
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
        int n;
        @(posedge pclk);
        if (!w)
            q.push_back({m, d});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_fail++;
            tally_and_finish;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m = 32'hffffffff);
        apb(1'b0, a, d, m);
    endtask
    task conv(input logic [2:0] s);
        wr(12'h00c, {24'h0, 3'b001, 2'b00, s});
        wr(12'h008, 32'h2f);
        res = 12'($urandom);
        sample_data <= res;
        wr(12'h008, 32'haf);
        wr(12'h008, 32'h2f);
        rd(12'h008, 32'h6f);
        cnt = 0;
        while (irq !== 1'b1 && cnt < 5000) begin
            @(posedge pclk);
            cnt++;
        end
        if (irq !== 1'b1) begin
            n_fail++;
            tally_and_finish;
        end
        check({31'h0, cnt >= (15 << s) - 4 && cnt <= (17 << s) + 6}, 1, "length");
        rd(12'h008, 32'h2f);
        rd(12'h018, 32'h3);
        wr(12'h01c, 32'h0);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 0, "masked irq");
        wr(12'h018, 32'h3);
        wr(12'h01c, 32'h1);
        rd(12'h018, 32'h0);
    endtask
    // ======================================================================
    // result checker fed by the queue
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            e = q.pop_front();
            check(prdata & e[63:32], e[31:0] & e[63:32], "prdata");
        end
    end
    initial begin
        #3000000;
        n_fail++;
        tally_and_finish;
    end
    // ======================================================================
    // main sequence
    initial begin
        void'($urandom(32'he352d328));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h008, 32'h0);
        rd(12'h00c, 32'h0);
        rd(12'h010, 32'h02);
        rd(12'h014, 32'h0);
        wr(12'h00c, 32'hdf);
        rd(12'h00c, 32'hdf);
        wr(12'h010, 32'hff);
        rd(12'h010, 32'h83);
        wr(12'h014, 32'hff);
        rd(12'h014, 32'h01);
        wr(12'h01c, 32'h1);
        for (int s = 0; s < 3; s++) begin
            conv(3'(s));
            rd(12'h000, {24'h0, res[11:4]});
            rd(12'h004, {24'h0, res[3:0], 4'h0});
            wr(12'h008, 32'h3f);
            rd(12'h000, {28'h0, res[11:8]});
            rd(12'h004, {24'h0, res[7:0]});
        end
        wr(12'h000, 32'hff);
        wr(12'h004, 32'h00);
        rd(12'h004, {24'h0, res[7:0]});
        wr(12'h008, 32'h2f);
        sample_data <= ~res;
        wr(12'h008, 32'haf);
        wr(12'h008, 32'h2f);
        wr(12'h008, 32'h0f);
        wr(12'h008, 32'h8f);
        wr(12'h008, 32'h0f);
        repeat (80) @(posedge pclk);
        rd(12'h008, 32'h0f);
        rd(12'h000, {24'h0, res[11:4]});
        rd(12'h040, 32'h0);
        wr(12'h040, 32'h5);
        tally_and_finish;
    end
endmodule
`default_nettype wire
